// [hw/cfg_port_pkg.sv]
package cfg_port_pkg;
    // Configuration scheme encodings.
    typedef enum logic [1:0] {
        serial_scheme,
        sync_parallel_scheme,
        async_parallel_scheme
    } scheme_e;
    localparam int data_width = 8;
    localparam int ready_bit = 7;
    localparam int serial_bit = 0;
    // Time to absorb one byte after it is latched.
    localparam int busy_time_ns = 400;
    localparam int clk_period_ns = 100;
    localparam int busy_cycles = (busy_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [15:0] default_image_bytes = 16'h0010;
    localparam logic [1:0] sync_stages = 2'h2;
endpackage

// [hw/sync_bus_if.sv]
`timescale 1ns/1ns
interface sync_bus_if #(parameter int width = 14);
    logic [width-1:0] raw;
    logic [width-1:0] synced;
    modport src (output raw, input synced);
    modport sync (input raw, output synced);
endinterface

// [hw/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync #(
    parameter int width = 14
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    sync_bus_if.sync bus
);
    logic [width-1:0] meta_q;
    logic [width-1:0] meta_d;
    logic [width-1:0] sync_q;
    logic [width-1:0] sync_d;

    // Two stages; only the second stage is visible to the block.
    always_comb begin
        meta_d = bus.raw;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign bus.synced = sync_q;
endmodule

// [hw/config_port_pin_behaviour.sv]
`timescale 1ns/1ns
// Summary of operation
// RQ1: Parallel schemes take each configuration byte whole from the eight data inputs.
// RQ2: Serial schemes sample only data line zero, one bit per clock.
// RQ3: Async parallel: after read strobe, drive ready/busy flag onto data line seven.
// RQ4: Completion status pulled low during configuration, released before and after.
// RQ5: Monitors detect completion by a low-to-high edge, not a high level.
// RQ6: Global output enable low forces all user I/O to high impedance.
// RQ7: Global clear low clears every internal register; here the two synchroniser stages clear only on reset.
// RQ8: Surrounding logic keeps test-port pins stable before and during configuration.
// RQ9: Ready/busy flag high when a byte can be taken, low otherwise.
// RQ10: Read strobe low makes the device drive the flag onto its data line.
// RQ11: Async parallel latches one byte on each write strobe rising edge; here an edge that comes while the busy count is still running is dropped.
module config_port_pin_behaviour
    import cfg_port_pkg::*;
#(
    parameter logic [15:0] image_bytes = cfg_port_pkg::default_image_bytes,
    parameter int user_io_width = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire cfg_port_pkg::scheme_e scheme_in,
    input wire logic config_start_in,
    input wire logic data_clock_in,
    input wire logic [7:0] data_in,
    input wire logic write_strobe_n_in,
    input wire logic read_strobe_n_in,
    input wire logic global_output_enable_in,
    input wire logic global_register_clear_n_in,
    input wire logic [user_io_width-1:0] user_io_out_in,
    input wire logic [user_io_width-1:0] user_io_oe_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe_out,
    output logic ready_busy_flag_out,
    output logic done_status_out,
    output logic done_status_oe_out,
    output logic [user_io_width-1:0] user_io_out,
    output logic [user_io_width-1:0] user_io_oe_out,
    output logic [7:0] cfg_byte_out,
    output logic cfg_byte_valid_out,
    output logic user_mode_out
);
    // Eight data lines plus six control lines pass the synchroniser.
    localparam int sync_w = 14;
    // Idle until started, loading until the image is complete, then user mode.
    typedef enum logic [1:0] {st_idle, st_load, st_user} state_e;

    // The eight data and six control pins cross two flip-flops before any logic here reads them; scheme and user I/O inputs do not.
    sync_bus_if #(.width(sync_w)) sbus ();
    assign sbus.raw = {data_in, write_strobe_n_in, read_strobe_n_in, data_clock_in,
                       global_output_enable_in, global_register_clear_n_in, config_start_in};

    pin_sync #(.width(sync_w)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .bus(sbus)
    );

    // Synchronised copies of the pins, unpacked in the order they were packed.
    logic [7:0] data_s;
    logic ws_n_s;
    logic rs_n_s;
    logic dclk_s;
    logic goe_s;
    logic gclr_n_s;
    logic start_s;
    assign {data_s, ws_n_s, rs_n_s, dclk_s, goe_s, gclr_n_s, start_s} = sbus.synced;

    // Previous synchronised strobe and clock levels feed the edge detectors.
    // A partial serial byte is lost if loading is cut short by a clear.
    state_e state_q, state_d;
    logic ws_n_q, ws_n_d;
    logic dclk_q, dclk_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [15:0] byte_cnt_q, byte_cnt_d;
    logic [7:0] busy_q, busy_d;
    logic [7:0] byte_q, byte_d;
    logic valid_q, valid_d;
    logic [7:0] dout_q, dout_d;
    logic flag_drive_q, flag_drive_d;

    // Count one more byte accepted into the configuration stream.
    function automatic logic [15:0] bump(input logic [15:0] cnt);
        bump = cnt + 16'h0001;
    endfunction

    // Rising edge of a synchronised pin against its level one clock earlier.
    function automatic logic rising(input logic prev, input logic now);
        rising = !prev && now;
    endfunction

    // Capture and sequencing. The busy count models time to absorb a byte;
    // a host that ignores the flag during it has its byte dropped.
    always_comb begin
        state_d = state_q;
        ws_n_d = ws_n_s;
        dclk_d = dclk_s;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        byte_cnt_d = byte_cnt_q;
        busy_d = (busy_q != 8'h00) ? busy_q - 8'h01 : busy_q;
        byte_d = byte_q;
        valid_d = 1'b0;
        flag_drive_d = flag_drive_q;
        case (state_q)
            st_idle: begin
                // A fresh start also clears any counts left over from an earlier load.
                if (start_s) begin
                    state_d = st_load;
                    byte_cnt_d = 16'h0000;
                    bit_cnt_d = 3'h0;
                    busy_d = 8'h00;
                end
            end
            st_load: begin
                // Only the active scheme's pins are watched; the others are ignored.
                case (scheme_in)
                    async_parallel_scheme: begin
                        if (rising(ws_n_q, ws_n_s) && busy_q == 8'h00) begin // RQ11
                            byte_d = data_s; // RQ1
                            valid_d = 1'b1;
                            byte_cnt_d = bump(byte_cnt_q);
                            busy_d = 8'(busy_cycles);
                        end
                    end
                    sync_parallel_scheme: begin
                        if (rising(dclk_q, dclk_s)) begin
                            byte_d = data_s; // RQ1
                            valid_d = 1'b1;
                            byte_cnt_d = bump(byte_cnt_q);
                        end
                    end
                    default: begin
                        if (rising(dclk_q, dclk_s)) begin
                            shift_d = {data_s[serial_bit], shift_q[7:1]}; // RQ2
                            bit_cnt_d = bit_cnt_q + 3'h1;
                            // The eighth bit completes the byte; the first bit lands in bit zero.
                            if (bit_cnt_q == 3'h7) begin
                                byte_d = {data_s[serial_bit], shift_q[7:1]};
                                valid_d = 1'b1;
                                byte_cnt_d = bump(byte_cnt_q);
                            end
                        end
                    end
                endcase
                // Leave loading as soon as the last byte of the image has been taken.
                if (byte_cnt_d == image_bytes) begin
                    state_d = st_user;
                end
            end
            st_user: begin
                // User mode holds until reset or a global clear; dropping start has no effect.
                if (start_s == 1'b0) begin
                    state_d = st_user;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
        // Flag is presented once the read strobe has been taken low.
        flag_drive_d = (scheme_in == async_parallel_scheme) && (state_q == st_load) && !rs_n_s; // RQ10
    end

    // Reset empties every internal register; global clear empties all but the two synchroniser stages.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !gclr_n_s) begin // RQ7
            state_q <= st_idle;
            ws_n_q <= 1'b1;
            dclk_q <= 1'b0;
            shift_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 16'h0000;
            busy_q <= 8'h00;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
            dout_q <= 8'h00;
            flag_drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ws_n_q <= ws_n_d;
            dclk_q <= dclk_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            busy_q <= busy_d;
            byte_q <= byte_d;
            valid_q <= valid_d;
            dout_q <= dout_d;
            flag_drive_q <= flag_drive_d;
        end
    end

    // Ready only while loading and once the busy count has run out.
    logic ready_now;
    assign ready_now = (state_q == st_load) && (busy_q == 8'h00); // RQ9

    // Only bit seven is ever driven back; the rest stay inputs.
    always_comb begin
        dout_d = 8'h00;
        dout_d[ready_bit] = ready_now; // RQ3
    end

    // The flag is driven only when asked for, so the host owns the data lines otherwise.
    assign data_out = dout_q;
    assign data_oe_out = {flag_drive_q, 7'h00}; // RQ3
    assign ready_busy_flag_out = ready_now; // RQ9

    // Open drain: only ever drives zero, and only while loading.
    assign done_status_out = 1'b0;
    assign done_status_oe_out = (state_q == st_load); // RQ4

    // User pins are live only in user mode and never when the override is low.
    assign user_io_out = user_io_out_in;
    assign user_io_oe_out = (goe_s && state_q == st_user) ? user_io_oe_in : '0; // RQ6

    // Captured byte and its one-cycle strobe for the configuration core.
    assign cfg_byte_out = byte_q;
    assign cfg_byte_valid_out = valid_q;
    assign user_mode_out = (state_q == st_user);
endmodule

// [verification/cfg_host_model.sv]
`timescale 1ns/1ns
// Host that feeds configuration data, moving its pins only at the falling clock edge.
module cfg_host_model (
    input wire logic clk_sys_in,
    output logic [7:0] data_out,
    output logic write_strobe_n_out,
    output logic data_clock_out
);
    initial begin
        data_out = 8'h00;
        write_strobe_n_out = 1'b1;
        data_clock_out = 1'b0;
    end
    // Three cycles per level, so the two-stage synchroniser always sees each level.
    task automatic hold3();
        repeat (3) @(negedge clk_sys_in);
    endtask
    // Mode 0 is serial LSB first, 1 clocked byte, 2 strobed byte.
    task automatic put_byte(input logic [1:0] mode, input logic [7:0] b);
        for (int i = 0; i < ((mode == 2'h0) ? 8 : 1); i++) begin
            data_out = (mode == 2'h0) ? {~b[7:1], b[i]} : b;
            hold3();
            if (mode == 2'h2) begin
                write_strobe_n_out = 1'b0;
                hold3();
                write_strobe_n_out = 1'b1;
            end else begin
                data_clock_out = 1'b1;
                hold3();
                data_clock_out = 1'b0;
            end
            hold3();
            // Released lines show the inverse, so a stale value never passes for data.
            data_out = ~data_out;
            // One more cycle keeps the next byte or bit out of this time step.
            @(negedge clk_sys_in);
        end
    endtask
endmodule

// [verification/config_port_pin_behaviour_monitor.sv]
`timescale 1ns/1ns
// Pin checks; waits of five samples cover the two synchroniser stages plus one register.
module config_port_pin_behaviour_monitor
    import cfg_port_pkg::*;
#(
    parameter int user_io_width = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire cfg_port_pkg::scheme_e scheme_in,
    input wire logic read_strobe_n_in,
    input wire logic global_output_enable_in,
    input wire logic global_register_clear_n_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_out,
    input wire logic ready_busy_flag_out,
    input wire logic done_status_out,
    input wire logic done_status_oe_out,
    input wire logic [user_io_width-1:0] user_io_oe_out,
    input wire logic cfg_byte_valid_out,
    input wire logic user_mode_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    done_value_a: assert property (!done_status_out) else $error("done driven high");
    io_override_a: assert property (!global_output_enable_in [*5] |-> user_io_oe_out == '0)
        else $error("io enabled under override");
    user_gate_a: assert property (!user_mode_out && !$past(user_mode_out) |-> user_io_oe_out == '0)
        else $error("io enabled before user mode");
    valid_pulse_a: assert property (cfg_byte_valid_out |=> !cfg_byte_valid_out) else $error("long valid");
    busy_hold_a: assert property (cfg_byte_valid_out && scheme_in == async_parallel_scheme
        |-> !ready_busy_flag_out [*4] ##1 (ready_busy_flag_out || user_mode_out)) else $error("busy span");
    flag_copy_a: assert property (data_oe_out[7] |-> data_out[7] == $past(ready_busy_flag_out))
        else $error("flag not on data line");
    read_drive_a: assert property ((!read_strobe_n_in [*4]) ##0 (done_status_oe_out &&
        scheme_in == async_parallel_scheme) |-> data_oe_out[7]) else $error("flag not driven");
    clear_state_a: assert property (!global_register_clear_n_in [*5]
        |-> !done_status_oe_out && !cfg_byte_valid_out && !user_mode_out) else $error("clear ignored");
    cover property (cfg_byte_valid_out);
    cover property ($rose(user_mode_out));
    cover property (data_oe_out[7]);
endmodule
bind config_port_pin_behaviour config_port_pin_behaviour_monitor #(.user_io_width(user_io_width)) u_mon (
    .clk_sys_in, .rst_n_in, .scheme_in, .read_strobe_n_in, .global_output_enable_in,
    .global_register_clear_n_in, .data_out, .data_oe_out, .ready_busy_flag_out, .done_status_out,
    .done_status_oe_out, .user_io_oe_out, .cfg_byte_valid_out, .user_mode_out);

// [verification/config_port_pin_behaviour_tb.sv]
`timescale 1ns/1ns
module config_port_pin_behaviour_tb;
    import cfg_port_pkg::*;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, config_start_in = 1'b0, read_strobe_n_in = 1'b1;
    logic goe = 1'b1, gclr_n = 1'b1, dclk, wsn, done_status_out, done_status_oe_out;
    logic ready_busy_flag_out, user_mode_out;
    logic [7:0] hd, data_out, data_oe_out, user_io_oe_out, cfg_byte_out, user_io_out;
    scheme_e scheme_in = async_parallel_scheme;
    int fails = 0, checks_done = 0;
    int done_rises = 0;
    logic done_line, done_line_q = 1'b1;
    // Small image keeps the run short.
    config_port_pin_behaviour #(.image_bytes(16'h0003)) u_config_port_pin_behaviour (
        .clk_sys_in, .rst_n_in, .scheme_in, .config_start_in, .data_clock_in(dclk), .data_in(hd),
        .write_strobe_n_in(wsn), .read_strobe_n_in, .global_output_enable_in(goe),
        // Side pins are held at fixed levels before and through loading, except the global clear that t_clear drops mid-load.
        .global_register_clear_n_in(gclr_n), .user_io_out_in(8'ha5), .user_io_oe_in(8'h3c), .data_out,
        .data_oe_out, .ready_busy_flag_out, .done_status_out, .done_status_oe_out, .user_io_out,
        .user_io_oe_out, .cfg_byte_out, .cfg_byte_valid_out(), .user_mode_out);
    cfg_host_model u_cfg_host_model (.clk_sys_in, .data_out(hd), .write_strobe_n_out(wsn), .data_clock_out(dclk));
    always #50 clk_sys_in = ~clk_sys_in;
    // Pull-up on the open-drain completion line; completion is a rising edge, not a high level.
    assign done_line = done_status_oe_out ? done_status_out : 1'b1;
    always @(negedge clk_sys_in) begin
        done_line_q <= done_line;
        if (done_line === 1'b1 && done_line_q === 1'b0) begin
            done_rises <= done_rises + 1;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reset, then start loading and confirm the done pin is pulled and user pins stay off.
    task automatic boot(input scheme_e s);
        scheme_in = s;
        rst_n_in = 1'b0;
        config_start_in = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        @(negedge clk_sys_in);
        config_start_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        chk(8'(done_status_oe_out), 8'h01);
        chk(user_io_oe_out, 8'h00);
    endtask
    task automatic t_async();
        int rises_at_start;
        boot(async_parallel_scheme);
        rises_at_start = done_rises;
        for (int i = 0; i < 3; i++) begin
            u_cfg_host_model.put_byte(2'h2, 8'h5a + 8'(i));
            chk(cfg_byte_out, 8'h5a + 8'(i));
            if (i == 0) begin
                read_strobe_n_in = 1'b0;
                repeat (5) @(negedge clk_sys_in);
                chk(8'({data_oe_out[7], data_out[7], ready_busy_flag_out}), 8'h07);
                read_strobe_n_in = 1'b1;
            end
        end
        repeat (4) @(negedge clk_sys_in);
        chk(8'({user_mode_out, done_status_oe_out, done_status_out}), 8'h04);
        chk(8'(done_rises - rises_at_start), 8'h01);
        chk(user_io_oe_out, 8'h3c);
        chk(user_io_out, 8'ha5);
        goe = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        chk(user_io_oe_out, 8'h00);
        goe = 1'b1;
    endtask
    task automatic t_serial();
        boot(serial_scheme);
        u_cfg_host_model.put_byte(2'h0, 8'hc3);
        chk(cfg_byte_out, 8'hc3);
    endtask
    task automatic t_clear();
        boot(sync_parallel_scheme);
        u_cfg_host_model.put_byte(2'h1, 8'h96);
        chk(cfg_byte_out, 8'h96);
        gclr_n = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        chk(8'({done_status_oe_out, user_mode_out}), 8'h00);
        chk(cfg_byte_out, 8'h00);
        gclr_n = 1'b1;
    endtask
    initial begin
        t_async();
        t_serial();
        t_clear();
        give_verdict();
    end
    // A hang is cut short and counted against the run.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        give_verdict();
    end
endmodule
